// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench
  import tpsf_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, aclk_en = 1'b1, tx_clk = 1'b0, tx_rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        send = 1'b0, slow = 1'b0, load = 1'b0, full_req = 1'b0;
  logic [2:0]  poll_req = 3'h0, tx_poll_addr;
  logic [15:0] load_val = 16'h0, tx_free_words;
  logic        tx_cell_write, tx_cell_start, tx_fifo_full, tx_polled_space_flag;
  logic        tx_polled_space_flag_oe;
  int          err_count = 0, checked = 0;
  localparam logic [31:0] RSTV [3] = '{TPSF_GLOBAL_RST, TPSF_CHANNEL_RST, TPSF_WATERMARK_RST};
  localparam logic [15:0] PFREE [7] = '{16'd12, 16'd8, 16'd6, 16'd5, 16'd9, 16'd10, 16'd12};
  localparam logic [6:0]  PEXP = 7'b0100111;
  // link clock offset so its edges never line up with system clock edges
  always #2 aclk = ~aclk;
  initial begin
    #13.1;
    forever #40 tx_clk = ~tx_clk;
  end
  tpsf_tx_polled_space_flag #(.CELL_WORDS(14), .SPACE_W(16)) dut (.*);
  tpsf_far_end #(.CELL_WORDS(14), .SPACE_W(16)) far_end (.*);
////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED wait expected answer seen none");
      give_verdict();
    end
  endtask
  // bus cycles; every wait ends on the answer or the bound
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  // config changes only while the link side is held in reset
  task cfg(input logic [31:0] g, input logic [31:0] c, input logic [31:0] w);
    logic [1:0] r;
    @(posedge tx_clk) tx_rst_n <= 1'b0;
    wr(TPSF_OFF_GLOBAL_CONFIG, g, r);
    wr(TPSF_OFF_TX_CHANNEL_CFG, c, r);
    wr(TPSF_OFF_TX_WATERMARK, w, r);
    repeat (4) @(posedge tx_clk);
    tx_rst_n <= 1'b1;
  endtask
  task ts(input logic [2:0] p, input logic [15:0] f, input logic fl);
    @(posedge tx_clk);
    poll_req <= p;
    load     <= 1'b1;
    load_val <= f;
    full_req <= fl;
    @(posedge tx_clk) load <= 1'b0;
    repeat (4) @(posedge tx_clk);
    @(negedge tx_clk);
  endtask
  // one cell into the last slot; free space left when the flag falls
  task drop(input logic [15:0] ld, input logic [15:0] ex, input logic sl);
    int n;
    ts(3'h5, ld, 1'b0);
    chk("flag before cell", 32'(tx_polled_space_flag), 32'h1);
    @(posedge tx_clk);
    slow <= sl;
    send <= 1'b1;
    @(posedge tx_clk) send <= 1'b0;
    for (n = 0; n < 50 && tx_polled_space_flag !== 1'b0; n++) @(negedge tx_clk);
    tmo(n);
    chk("free at drop", 32'(tx_free_words), 32'(ex));
    repeat (40) @(posedge tx_clk);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rd(8'(4 * i), d, r);
      chk("reset value", d, RSTV[i]);
    end
    rd(8'h10, d, r);
    chk("unmapped resp", 32'(r), 32'(TPSF_RESP_SLVERR));
    chk("unmapped data", d, 32'h0);
    wr(TPSF_OFF_TX_STATUS, 32'h1, r);
    chk("status write resp", 32'(r), 32'(TPSF_RESP_SLVERR));
    $display("test registers done");
    // byte 9 falls on word 3, far ahead of the last word
    cfg(32'h5, 32'h0900, TPSF_WATERMARK_RST);
    ts(3'h5, 16'd40, 1'b0);
    chk("flag room", 32'(tx_polled_space_flag), 32'h1);
    chk("oe polled", 32'(tx_polled_space_flag_oe), 32'h1);
    rd(TPSF_OFF_TX_STATUS, d, r);
    chk("status flag", d, 32'h1);
    ts(3'h2, 16'd40, 1'b0);
    chk("oe unpolled", 32'(tx_polled_space_flag_oe), 32'h0);
    ts(3'h5, 16'd13, 1'b0);
    chk("flag no room", 32'(tx_polled_space_flag), 32'h0);
    ts(3'h5, 16'd40, 1'b1);
    chk("flag full", 32'(tx_polled_space_flag), 32'h0);
    drop(16'd20, 16'd17, 1'b0);
    $display("test cell done");
    // position 60 acts as 48, slow writer
    cfg(32'h5, 32'h3c00, TPSF_WATERMARK_RST);
    drop(16'd27, 16'd14, 1'b1);
    $display("test clamp done");
    // packet mode, two-cycle poll, near-empty 10, near-full 6
    cfg(32'h15, 32'h3001, 32'h0006000a);
    ts(3'h2, 16'd12, 1'b0);
    for (i = 0; i < 7; i++) begin
      ts(3'h5, PFREE[i], i == 6);
      chk("packet flag", 32'(tx_polled_space_flag), 32'(PEXP[i]));
    end
    chk("oe delayed poll", 32'(tx_polled_space_flag_oe), 32'h1);
    $display("test packet done");
    give_verdict();
  end
endmodule

// ===== dv/tpsf_chk.sv
`timescale 1ns/100ps
module tpsf_chk
  import tpsf_pkg::*;
#(
  parameter int CELL_WORDS = 14,
  parameter int SPACE_W    = 16
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               tx_clk,
  input wire logic               tx_rst_n,
  input wire logic [2:0]         tx_poll_addr,
  input wire logic               tx_cell_write,
  input wire logic               tx_cell_start,
  input wire logic [SPACE_W-1:0] tx_free_words,
  input wire logic               tx_fifo_full,
  input wire logic               tx_polled_space_flag,
  input wire logic               tx_polled_space_flag_oe
);
////////////////////////////////////////
  logic [31:0] gcfg_reg, ccfg_reg, wm_reg;
  logic [5:0]  wcnt_reg;
  logic [2:0]  age_reg;
  // shadow config; only sees writes whose address and data go in together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gcfg_reg <= TPSF_GLOBAL_RST;
      ccfg_reg <= TPSF_CHANNEL_RST;
      wm_reg   <= TPSF_WATERMARK_RST;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
      if (s_axi_awaddr == TPSF_OFF_GLOBAL_CONFIG) gcfg_reg <= s_axi_wdata;
      if (s_axi_awaddr == TPSF_OFF_TX_CHANNEL_CFG) ccfg_reg <= s_axi_wdata;
      if (s_axi_awaddr == TPSF_OFF_TX_WATERMARK) wm_reg <= s_axi_wdata;
    end
  end
  // decode of the shadow; positions out of range clamp
  wire [5:0]  pos  = ccfg_reg[TPSF_DEASSERT_LSB +: TPSF_DEASSERT_W];
  wire [5:0]  posc = (pos < TPSF_DEASSERT_MIN) ? TPSF_DEASSERT_MIN :
                     (pos > TPSF_DEASSERT_MAX) ? TPSF_DEASSERT_MAX : pos;
  wire [5:0]  tgt  = (posc + 6'h04) >> 2;
  wire [5:0]  widx = tx_cell_start ? 6'h01 : wcnt_reg + 6'h01;
  wire        ok   = age_reg == 3'h4;
  wire        pkt  = gcfg_reg[TPSF_PKT_MODE_BIT];
  wire        dsel = ccfg_reg[TPSF_DELAY_SEL_BIT];
  wire        hit  = tx_poll_addr == gcfg_reg[TPSF_BASE_LSB +: TPSF_BASE_W];
  wire [31:0] free = 32'(tx_free_words);
  wire [31:0] ne   = 32'(wm_reg[TPSF_NE_LSB +: TPSF_MARK_W]);
  wire [31:0] nf   = 32'(wm_reg[TPSF_NF_LSB +: TPSF_MARK_W]);
  // config crosses after tx reset release, so checks wait four edges
  always_ff @(posedge tx_clk) begin
    if (!tx_rst_n) begin
      wcnt_reg <= 6'h00;
      age_reg  <= 3'h0;
    end else begin
      if (tx_cell_write) wcnt_reg <= widx;
      if (!ok) age_reg <= age_reg + 3'h1;
    end
  end
  default clocking dc @(posedge tx_clk); endclocking
  default disable iff (!tx_rst_n);
  sequence poll_held;
    (ok && hit) [*3];
  endsequence
  sequence last_slot_word;
    ok && !pkt && tx_cell_write && widx == tgt && free < 2 * CELL_WORDS;
  endsequence
  oe_poll_drive_a: assert property (poll_held |-> ##[0:1] tx_polled_space_flag_oe)
    else $error("oe missing after poll match");
  oe_release_a: assert property (ok && !hit |-> ##[1:2] !tx_polled_space_flag_oe)
    else $error("oe kept without poll match");
  oe_single_a: assert property (ok && !dsel && $rose(tx_polled_space_flag_oe) |-> $past(hit))
    else $error("oe rose without match");
  oe_double_a: assert property (ok && dsel && $rose(tx_polled_space_flag_oe)
    |-> $past(hit) && $past(hit, 2)) else $error("oe rose before two matches");
  cell_room_a: assert property (ok && !pkt && !tx_fifo_full && free >= 2 * CELL_WORDS
    |=> tx_polled_space_flag) else $error("cell flag low with room");
  cell_none_a: assert property (ok && !pkt && (tx_fifo_full || free < CELL_WORDS)
    |=> !tx_polled_space_flag) else $error("cell flag high without room");
  cell_drop_a: assert property (last_slot_word |=> !tx_polled_space_flag)
    else $error("flag not dropped at selected byte");
  pkt_set_a: assert property (ok && pkt && !tx_fifo_full && free >= nf && free >= ne
    |=> tx_polled_space_flag) else $error("packet flag low above near-empty");
  pkt_clear_a: assert property (ok && pkt && (tx_fifo_full || free < nf)
    |=> !tx_polled_space_flag) else $error("packet flag high when full");
  pkt_hold_a: assert property (ok && pkt && !tx_fifo_full && free >= nf && free < ne
    |=> $stable(tx_polled_space_flag)) else $error("packet flag moved between marks");
endmodule
bind tpsf_tx_polled_space_flag tpsf_chk #(.CELL_WORDS(CELL_WORDS), .SPACE_W(SPACE_W)) chk_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .tx_clk, .tx_rst_n, .tx_poll_addr, .tx_cell_write, .tx_cell_start,
  .tx_free_words, .tx_fifo_full, .tx_polled_space_flag, .tx_polled_space_flag_oe);

// ===== dv/tpsf_far_end.sv
`timescale 1ns/100ps
module tpsf_far_end #(
  parameter int CELL_WORDS = 14,
  parameter int SPACE_W    = 16
) (
  input  wire logic               tx_clk,
  input  wire logic               tx_rst_n,
  input  wire logic [2:0]         poll_req,
  input  wire logic               send,
  input  wire logic               slow,
  input  wire logic               load,
  input  wire logic [SPACE_W-1:0] load_val,
  input  wire logic               full_req,
  output logic      [2:0]         tx_poll_addr = 3'h0,
  output logic                    tx_cell_write = 1'b0,
  output logic                    tx_cell_start = 1'b0,
  output logic      [SPACE_W-1:0] tx_free_words = '0,
  output logic                    tx_fifo_full = 1'b0
);
////////////////////////////////////////
  logic [5:0] cnt_reg  = 6'h00;
  logic       pace_reg = 1'b0;
  // writer: one whole cell per send, each cycle or every other one when slow
  always @(posedge tx_clk) begin
    tx_poll_addr  <= poll_req;
    tx_fifo_full  <= full_req;
    pace_reg      <= ~pace_reg;
    tx_cell_write <= 1'b0;
    tx_cell_start <= 1'b0;
    if (load) tx_free_words <= load_val;
    else if (tx_cell_write) tx_free_words <= tx_free_words - SPACE_W'(1);
    if (!tx_rst_n) cnt_reg <= 6'h00;
    else if (cnt_reg == 6'h00) cnt_reg <= send ? 6'h01 : 6'h00;
    else if (!slow || pace_reg) begin
      tx_cell_write <= 1'b1;
      tx_cell_start <= cnt_reg == 6'h01;
      cnt_reg       <= (cnt_reg == 6'(CELL_WORDS)) ? 6'h00 : cnt_reg + 6'h01;
    end
  end
endmodule

// ===== rtl/tpsf_pkg.sv
package tpsf_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] TPSF_OFF_GLOBAL_CONFIG   = 8'h00;
  localparam logic [7:0] TPSF_OFF_TX_CHANNEL_CFG  = 8'h04;
  localparam logic [7:0] TPSF_OFF_TX_WATERMARK    = 8'h08;
  localparam logic [7:0] TPSF_OFF_TX_STATUS       = 8'h0c;
  // global_config_reg fields
  localparam int         TPSF_BASE_LSB            = 0;
  localparam int         TPSF_BASE_W              = 3;
  localparam int         TPSF_PKT_MODE_BIT        = 4;
  // tx_channel_config_reg fields
  localparam int         TPSF_DELAY_SEL_BIT       = 0;
  localparam int         TPSF_DEASSERT_LSB        = 8;
  localparam int         TPSF_DEASSERT_W          = 6;
  // tx_watermark_reg fields
  localparam int         TPSF_NE_LSB              = 0;
  localparam int         TPSF_NF_LSB              = 16;
  localparam int         TPSF_MARK_W              = 16;
  // reset values
  localparam logic [31:0] TPSF_GLOBAL_RST         = 32'h0000_0000;
  localparam logic [31:0] TPSF_CHANNEL_RST        = 32'h0000_3000;
  localparam logic [31:0] TPSF_WATERMARK_RST      = 32'h0004_0008;
  // valid deassert byte positions
  localparam logic [5:0] TPSF_DEASSERT_MIN        = 6'h09;
  localparam logic [5:0] TPSF_DEASSERT_MAX        = 6'h30;
  // axi responses
  localparam logic [1:0] TPSF_RESP_OKAY           = 2'h0;
  localparam logic [1:0] TPSF_RESP_SLVERR         = 2'h2;
  // bytes per bus word at the link
  localparam int         TPSF_BYTES_PER_WORD      = 4;
endpackage

// ===== rtl/tpsf_tx_polled_space_flag.sv
`timescale 1ns/100ps
module tpsf_tx_polled_space_flag
  import tpsf_pkg::*;
#(
  parameter int CELL_WORDS = 14,
  parameter int SPACE_W    = 16
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               aclk_en,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               tx_clk,
  input  wire logic               tx_rst_n,
  input  wire logic [2:0]         tx_poll_addr,
  input  wire logic               tx_cell_write,
  input  wire logic               tx_cell_start,
  input  wire logic [SPACE_W-1:0] tx_free_words,
  input  wire logic               tx_fifo_full,
  output logic                    tx_polled_space_flag,
  output logic                    tx_polled_space_flag_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // register file on the system clock
  //
  // map, one aligned 32-bit word per register:
  //   0x00 global_config_reg: poll base address and packet mode select
  //   0x04 tx_channel_config_reg: poll_delay_select and drop byte position
  //   0x08 tx_watermark_reg: near-empty mark low half, near-full mark high half
  //   0x0c status: synced copy of the flag, read only
  //
  // slave behaviour in short:
  //   - awready and wready are combinational from the parked flags; each is low while its word is parked
  //   - address and data are parked separately, in either order
  //   - the write fires once both are parked and no response is pending
  //   - bvalid stands until bready is seen high
  //   - a read is taken whenever arvalid is high and no read data is pending
  //   - rvalid stands until rready is seen high
  //   - unmapped offsets answer slverr; reads of them return zero
  //   - a write to the status word changes nothing and answers slverr
  //
  // limitation: only one write and one read may be in flight at a time;
  // a master that pipelines requests is throttled by the ready outputs
  //
  // aclk_en freezes every register of this domain; the link side keeps
  // running from tx_clk, which is why its config copy is resynchronised

  logic [31:0] global_config_reg;
  logic [31:0] tx_channel_config_reg;
  logic [31:0] tx_watermark_reg;
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [1:0]  flag_sync_reg;

  function automatic logic [31:0] tpsf_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // address and data may arrive in either order; each is held until both are in
  wire         do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
  wire         wr_glob   = aw_addr_reg == TPSF_OFF_GLOBAL_CONFIG;
  wire         wr_chan   = aw_addr_reg == TPSF_OFF_TX_CHANNEL_CFG;
  wire         wr_mark   = aw_addr_reg == TPSF_OFF_TX_WATERMARK;
  wire         wr_hit    = wr_glob || wr_chan || wr_mark;
  wire         rd_take   = s_axi_arvalid && !rvalid_reg;
  wire  [31:0] rd_status = {31'h0000_0000, flag_sync_reg[1]};
  wire         rd_hit    = s_axi_araddr == TPSF_OFF_GLOBAL_CONFIG
                        || s_axi_araddr == TPSF_OFF_TX_CHANNEL_CFG
                        || s_axi_araddr == TPSF_OFF_TX_WATERMARK
                        || s_axi_araddr == TPSF_OFF_TX_STATUS;
  wire  [31:0] rd_mux    = (s_axi_araddr == TPSF_OFF_GLOBAL_CONFIG)  ? global_config_reg
                         : (s_axi_araddr == TPSF_OFF_TX_CHANNEL_CFG) ? tx_channel_config_reg
                         : (s_axi_araddr == TPSF_OFF_TX_WATERMARK)   ? tx_watermark_reg
                         : (s_axi_araddr == TPSF_OFF_TX_STATUS)      ? rd_status
                         : 32'h0000_0000;

  assign s_axi_awready = !aw_held_reg && aclk_en;
  assign s_axi_wready  = !w_held_reg && aclk_en;
  assign s_axi_arready = !rvalid_reg && aclk_en;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (aclk_en) begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_config_reg     <= TPSF_GLOBAL_RST;
      tx_channel_config_reg <= TPSF_CHANNEL_RST;
      tx_watermark_reg      <= TPSF_WATERMARK_RST;
      bvalid_reg            <= 1'b0;
      bresp_reg             <= TPSF_RESP_OKAY;
    end else if (aclk_en) begin
      if (do_write) begin
        if (wr_glob) global_config_reg <= tpsf_merge(global_config_reg, w_data_reg, w_strb_reg);
        if (wr_chan) tx_channel_config_reg <= tpsf_merge(tx_channel_config_reg, w_data_reg,
                                                         w_strb_reg);
        if (wr_mark) tx_watermark_reg <= tpsf_merge(tx_watermark_reg, w_data_reg, w_strb_reg);
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? TPSF_RESP_OKAY : TPSF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read response, unmapped answers slverr with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= TPSF_RESP_OKAY;
    end else if (aclk_en) begin
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_hit ? TPSF_RESP_OKAY : TPSF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // flag state back into the system domain for status reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_sync_reg <= 2'b00;
    end else if (aclk_en) begin
      flag_sync_reg <= {flag_sync_reg[0], tx_polled_space_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration into the link domain; quasi-static, each bit double-flopped
  // so software must not change it while polling is live

  // packing of the crossing word, most significant first:
  //   base address, packet mode, poll delay select, drop position,
  //   near-empty mark, near-full mark
  //
  // hazard: the bits are not gray coded and carry no handshake, so a
  // change caught mid-edge can be seen half old and half new for a cycle;
  // holding the link side in reset while reprogramming avoids that
  //
  // trade-off: a full request/acknowledge crossing would cost a few more
  // flops and a software wait; the settings are static in practice

  localparam int CFG_W = TPSF_BASE_W + 2 + TPSF_DEASSERT_W + 2 * TPSF_MARK_W;

  wire [CFG_W-1:0] cfg_sys = {global_config_reg[TPSF_BASE_LSB +: TPSF_BASE_W],
                              global_config_reg[TPSF_PKT_MODE_BIT],
                              tx_channel_config_reg[TPSF_DELAY_SEL_BIT],
                              tx_channel_config_reg[TPSF_DEASSERT_LSB +: TPSF_DEASSERT_W],
                              tx_watermark_reg[TPSF_NE_LSB +: TPSF_MARK_W],
                              tx_watermark_reg[TPSF_NF_LSB +: TPSF_MARK_W]};

  logic [CFG_W-1:0] cfg_meta_reg;
  logic [CFG_W-1:0] cfg_link_reg;

  always_ff @(posedge tx_clk) begin
    if (!tx_rst_n) begin
      cfg_meta_reg <= '0;
      cfg_link_reg <= '0;
    end else begin
      cfg_meta_reg <= cfg_sys;
      cfg_link_reg <= cfg_meta_reg;
    end
  end

  wire [2:0]             base_addr  = cfg_link_reg[CFG_W-1 -: TPSF_BASE_W];
  wire                   pkt_mode   = cfg_link_reg[CFG_W-1-TPSF_BASE_W];
  wire                   delay_sel  = cfg_link_reg[CFG_W-2-TPSF_BASE_W];
  wire [5:0]             deassert_b = cfg_link_reg[2*TPSF_MARK_W +: TPSF_DEASSERT_W];
  wire [TPSF_MARK_W-1:0] near_empty = cfg_link_reg[TPSF_MARK_W +: TPSF_MARK_W];
  wire [TPSF_MARK_W-1:0] near_full  = cfg_link_reg[0 +: TPSF_MARK_W];

  ////////////////////////////////////////////////////////////////////////////
  // link domain: poll match, cell tracking and flag
  //
  // poll match: the address must equal the base for one edge, or two
  // when poll_delay_select is set, before the flag pin is driven; the
  // counter saturates at two so a long poll keeps the pin driven
  //
  // cell mode: the flag mirrors room for a whole cell; while the cell
  // being written takes the last slot, it is pulled low at the edge that
  // samples the word holding the chosen payload byte, so the writer learns
  // early that the next cell will not fit
  //
  // word count: word one is the first of a cell, marked by tx_cell_start;
  // the header is taken as five bytes and each word carries four bytes
  //
  // packet mode: low when full or below near-full, high at or above
  // near-empty, and unchanged between the two marks (hysteresis)
  //
  // limitation: the free word count and full flag come from the fifo
  // logic on the same clock and are used as they stand, unsynchronised

  logic [1:0] match_cnt_reg;
  logic [5:0] word_idx_reg;
  logic       flag_reg;
  logic       flag_next;

  // out-of-range positions clamp to the nearest legal byte
  wire [5:0] pos_eff    = (deassert_b < TPSF_DEASSERT_MIN) ? TPSF_DEASSERT_MIN
                        : (deassert_b > TPSF_DEASSERT_MAX) ? TPSF_DEASSERT_MAX
                        : deassert_b;
  // word holding the payload byte, after the 5-byte header, 4 bytes per word
  wire [5:0] target_wd  = 6'((6'd4 + pos_eff) >> 2);
  wire       addr_hit   = tx_poll_addr == base_addr;
  wire [1:0] need_cnt   = delay_sel ? 2'd2 : 2'd1;
  wire       drive_en   = addr_hit && (match_cnt_reg >= need_cnt);
  wire [SPACE_W-1:0] cell_sz = SPACE_W'(CELL_WORDS);
  wire       cell_room  = !tx_fifo_full && (tx_free_words >= cell_sz);
  wire       last_slot  = tx_free_words < SPACE_W'(2 * CELL_WORDS);
  // index of the word sampled at this edge, so the drop lands on it, not the next
  wire [5:0] cur_idx    = tx_cell_start ? 6'd1 : 6'(word_idx_reg + 6'd1);
  wire       cur_wd_hit = tx_cell_write && (cur_idx == target_wd);
  wire       pkt_up     = 32'(tx_free_words) >= 32'(near_empty);
  wire       pkt_down   = tx_fifo_full
                       || 32'(tx_free_words) < 32'(near_full);

  // flag decision per mode
  always_comb begin
    flag_next = flag_reg;
    if (pkt_mode) begin
      if (pkt_down) begin
        flag_next = 1'b0;
      end else if (pkt_up) begin
        flag_next = 1'b1;
      end
    end else begin
      flag_next = cell_room;
      if (last_slot && cur_wd_hit) begin
        flag_next = 1'b0;
      end
    end
  end

  // match counter and word index within the current cell
  always_ff @(posedge tx_clk) begin
    if (!tx_rst_n) begin
      match_cnt_reg <= 2'd0;
      word_idx_reg  <= 6'd0;
    end else begin
      if (!addr_hit) match_cnt_reg <= 2'd0;
      else if (match_cnt_reg != 2'd2) match_cnt_reg <= match_cnt_reg + 2'd1;
      if (tx_cell_write) begin
        word_idx_reg <= cur_idx;
      end
    end
  end

  // flag and its enable change only on link clock edges
  always_ff @(posedge tx_clk) begin
    if (!tx_rst_n) begin
      flag_reg                <= 1'b0;
      tx_polled_space_flag_oe <= 1'b0;
    end else begin
      flag_reg                <= flag_next;
      tx_polled_space_flag_oe <= drive_en;
    end
  end

  assign tx_polled_space_flag = flag_reg;

endmodule
